// *** cmpc_analog_model.sv ***
// Purpose: comparator cores and gate timer clock
// Assumes: results change just after pclk edges
// Notes:   timer clock holds its level while stopped
module cmpc_analog_model (
  input  logic       pclk,
  input  logic [1:0] want,
  input  logic       tick_en,
  output logic [1:0] raw_result,
  output logic       timer_clk_post
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div;
  logic [7:0] ticks;
  initial
  begin
    raw_result = 2'h0;
    timer_clk_post = 1'b0;
    div = 2'h0;
    ticks = 8'h0;
  end
  always @(posedge pclk) raw_result <= want;
  // Prescaler by four feeds the sync latch clock
  always @(posedge pclk)
  begin
    if (tick_en)
    begin
      div <= div + 2'h1;
      timer_clk_post <= div[1];
    end
  end
  always @(posedge timer_clk_post) ticks <= ticks + 8'h1;
endmodule

// *** cmpc_defs.svh ***
// Purpose: constants for the comparator digital control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   types live in cmpc_pkg
// How it works
// R1 - Enable bit powers comparator, else minimum current
// R2 - Disabled comparator disconnects all inputs
// R3 - Result in control bit and mirror register
// R4 - Result latched every instruction cycle
// R5 - Invert select complements raw result
// R6 - Hysteresis select drives hysteresis control
// R7 - Result offered as gate timer source
// R8 - Sync select latches on timer clock fall
// R9 - Sync latch uses post-prescaler timer clock
// R10 - Timer counts rising, sync result updates falling
// R11 - Software should enable sync when gating
// R12 - Rise and fall detectors per comparator
// R13 - Enabled edge sets interrupt flag
// R14 - Edge set beats software clear
// R15 - Only software clears the flag
// R16 - Software sets all enables for interrupts
// R17 - Invert or enable toggles count as edges
// R18 - Three-bit positive input select
// R19 - Three-bit negative input select
// R20 - Result routable to pin, pin set output
// R21 - Result unsettled after input selection change
// R22 - Negative select encoding table
// R23 - Positive select encoding table
// R24 - Sync clear gives unlatched pass-through result
// R25 - Two independent comparator channels
// R26 - Edges compare result with previous cycle
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CMPC_A_CTRL_A     12'h000
`define CMPC_A_CTRL_B     12'h004
`define CMPC_A_PSEL       12'h008
`define CMPC_A_NSEL       12'h00c
`define CMPC_CH_STRIDE    12'h010
`define CMPC_A_MIRROR     12'h020
`define CMPC_A_IRQ_FLAG   12'h024
`define CMPC_A_IRQ_EN     12'h028

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMPC_B_ENABLE     7
`define CMPC_B_RESULT     6
`define CMPC_B_INVERT     4
`define CMPC_B_HYST       1
`define CMPC_B_SYNC       0
`define CMPC_B_RISE       1
`define CMPC_B_FALL       0
`define CMPC_SEL_W        3

// ----------------------------------------------------------------
// Input select codes
// ----------------------------------------------------------------
`define CMPC_SEL_DAC      3'h5
`define CMPC_SEL_FVR      3'h6
`define CMPC_SEL_GND      3'h7
`define CMPC_NSEL_PINMAX  3'h3
`define CMPC_PSEL_PINMAX  3'h1

`endif

// *** cmpc_pkg.sv ***
// Purpose: types for the comparator digital control block
// Assumes: included constants in cmpc_defs.svh
// Notes:   one struct per channel of analog controls
package cmpc_pkg;

  // Analog routing for one comparator
  typedef struct packed {
    logic       power_on;
    logic       hysteresis;
    logic       plus_pin_en;
    logic [1:0] plus_pin;
    logic       plus_dac;
    logic       plus_fvr;
    logic       plus_gnd;
    logic       minus_pin_en;
    logic [1:0] minus_pin;
    logic       minus_fvr;
    logic       minus_gnd;
  } cmpc_analog_t;

  // Control bits of one comparator
  typedef struct packed {
    logic       enable;
    logic       invert;
    logic       hysteresis;
    logic       sync;
    logic       rise_en;
    logic       fall_en;
    logic [2:0] psel;
    logic [2:0] nsel;
  } cmpc_ctrl_t;

endpackage

// *** cmpc_top.sv ***
// Purpose: digital control of two analog comparators behind APB
// Assumes: raw analog results are synchronous to pclk; the gate
//          timer clock (post-prescaler) is sampled as a level
// Notes:   outputs leave from flip-flops
//
// Chosen here: the APB slave port and the register addresses.
`include "cmpc_defs.svh"

module cmpc_top #(
  parameter int NUM_CH = 2
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       clk_en,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [NUM_CH-1:0]          raw_result,
  input  wire logic                       timer_clk_post,
  output cmpc_pkg::cmpc_analog_t [NUM_CH-1:0] analog_ctrl,
  output logic      [NUM_CH-1:0]          gate_source,
  output logic      [NUM_CH-1:0]          pin_result,
  output logic      [NUM_CH-1:0]          cmp_irq_flag
);
  import cmpc_pkg::*;

  // Refuse channel counts the register map cannot serve
  if (NUM_CH != 2)
  begin : g_bad_ch
    $error("cmpc_top serves exactly two channels");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  cmpc_ctrl_t [NUM_CH-1:0] ctrl;
  logic       [NUM_CH-1:0] cmp_irq_enable;
  logic       [NUM_CH-1:0] cmp_result_bit;
  logic       [NUM_CH-1:0] prev_result;
  logic       [NUM_CH-1:0] sync_result;
  logic       [NUM_CH-1:0] next_flag;
  logic                    tclk_d;
  logic                    wr_acc;
  logic                    rd_acc;
  logic       [31:0]       next_rdata;
  logic                    next_err;

  assign wr_acc = clk_en && psel && penable && pwrite && pready;
  assign rd_acc = clk_en && psel && penable && !pwrite && pready;

  function automatic logic is_ch(input logic [11:0] a,
                                 input logic [11:0] base,
                                 input int          ch);
    is_ch = (a == base + 12'(ch) * `CMPC_CH_STRIDE);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    logic m;
    m = (a == `CMPC_A_MIRROR) || (a == `CMPC_A_IRQ_FLAG) ||
        (a == `CMPC_A_IRQ_EN);
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (is_ch(a, `CMPC_A_CTRL_A, c) || is_ch(a, `CMPC_A_CTRL_B, c) ||
          is_ch(a, `CMPC_A_PSEL, c) || is_ch(a, `CMPC_A_NSEL, c))
        m = 1'b1;
    end
    mapped = m;
  endfunction

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (clk_en)
      pready <= psel && !penable;
  end

  // ----------------------------------------------------------------
  // Control registers per channel
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)  // see R25
    begin : g_ch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ctrl[g] <= '0;
        else if (wr_acc && pstrb[0])
        begin
          if (is_ch(paddr, `CMPC_A_CTRL_A, g))
          begin
            ctrl[g].enable     <= pwdata[`CMPC_B_ENABLE];
            ctrl[g].invert     <= pwdata[`CMPC_B_INVERT];
            ctrl[g].hysteresis <= pwdata[`CMPC_B_HYST];
            ctrl[g].sync       <= pwdata[`CMPC_B_SYNC];
          end
          if (is_ch(paddr, `CMPC_A_CTRL_B, g))
          begin
            ctrl[g].rise_en <= pwdata[`CMPC_B_RISE];
            ctrl[g].fall_en <= pwdata[`CMPC_B_FALL];
          end
          if (is_ch(paddr, `CMPC_A_PSEL, g))
            ctrl[g].psel <= pwdata[`CMPC_SEL_W-1:0];    // see R18
          if (is_ch(paddr, `CMPC_A_NSEL, g))
            ctrl[g].nsel <= pwdata[`CMPC_SEL_W-1:0];    // see R19
        end
      end

      // Instruction-cycle latch; polarity applied here
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cmp_result_bit[g] <= 1'b0;
        else if (clk_en)
          cmp_result_bit[g] <= (raw_result[g] && ctrl[g].enable)
                               ^ ctrl[g].invert;  // see R4 see R5 see R17
      end

      // Previous value for edge detection
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          prev_result[g] <= 1'b0;
        else if (clk_en)
          prev_result[g] <= cmp_result_bit[g];  // see R26
      end

      // Sync latch on falling edge of post-prescaler timer clock
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          sync_result[g] <= 1'b0;
        else if (clk_en && tclk_d && !timer_clk_post)
          sync_result[g] <= cmp_result_bit[g];  // see R8 see R9 see R10
      end

      // Outputs to timer gate and pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gate_source[g] <= 1'b0;
          pin_result[g]  <= 1'b0;
        end
        else if (clk_en)
        begin
          // see R7 see R20 see R24
          gate_source[g] <= ctrl[g].sync ? sync_result[g]
                                         : cmp_result_bit[g];
          pin_result[g]  <= ctrl[g].sync ? sync_result[g]
                                         : cmp_result_bit[g];
        end
      end

      // Edge detectors and flag; set beats clear
      always_comb
      begin
        next_flag[g] = cmp_irq_flag[g];
        if (wr_acc && pstrb[0] && paddr == `CMPC_A_IRQ_FLAG &&
            pwdata[g])
          next_flag[g] = 1'b0;                    // see R15
        if ((cmp_result_bit[g] && !prev_result[g] && ctrl[g].rise_en) ||
            (!cmp_result_bit[g] && prev_result[g] && ctrl[g].fall_en))
          next_flag[g] = 1'b1;                    // see R12 see R13 see R14
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cmp_irq_flag[g] <= 1'b0;
        else if (clk_en)
          cmp_irq_flag[g] <= next_flag[g];
      end

      // Analog controls; everything cut when disabled
      // Select changes apply at once, result settles later; see R21
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          analog_ctrl[g] <= '0;
        else if (clk_en)
        begin
          analog_ctrl[g] <= '0;                   // see R2
          if (ctrl[g].enable)                      // see R1
          begin
            analog_ctrl[g].power_on   <= 1'b1;
            analog_ctrl[g].hysteresis <= ctrl[g].hysteresis;  // see R6
            // see R23
            analog_ctrl[g].plus_pin_en <=
              ctrl[g].psel <= `CMPC_PSEL_PINMAX;
            analog_ctrl[g].plus_pin <= ctrl[g].psel[1:0];
            analog_ctrl[g].plus_dac <= ctrl[g].psel == `CMPC_SEL_DAC;
            analog_ctrl[g].plus_fvr <= ctrl[g].psel == `CMPC_SEL_FVR;
            analog_ctrl[g].plus_gnd <= ctrl[g].psel == `CMPC_SEL_GND;
            // see R22
            analog_ctrl[g].minus_pin_en <=
              ctrl[g].nsel <= `CMPC_NSEL_PINMAX;
            analog_ctrl[g].minus_pin <= ctrl[g].nsel[1:0];
            analog_ctrl[g].minus_fvr <= ctrl[g].nsel == `CMPC_SEL_FVR;
            analog_ctrl[g].minus_gnd <= ctrl[g].nsel == `CMPC_SEL_GND;
          end
        end
      end
    end
  endgenerate

  // Timer clock level history for the falling-edge strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tclk_d <= 1'b0;
    else if (clk_en)
      tclk_d <= timer_clk_post;
  end

  // Interrupt enable register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_irq_enable <= '0;
    else if (wr_acc && pstrb[0] && paddr == `CMPC_A_IRQ_EN)
      cmp_irq_enable <= pwdata[NUM_CH-1:0];
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = '0;
    next_err   = !mapped(paddr);
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (is_ch(paddr, `CMPC_A_CTRL_A, c))
      begin
        next_rdata[`CMPC_B_ENABLE] = ctrl[c].enable;
        next_rdata[`CMPC_B_RESULT] = cmp_result_bit[c];  // see R3
        next_rdata[`CMPC_B_INVERT] = ctrl[c].invert;
        next_rdata[`CMPC_B_HYST]   = ctrl[c].hysteresis;
        next_rdata[`CMPC_B_SYNC]   = ctrl[c].sync;
      end
      if (is_ch(paddr, `CMPC_A_CTRL_B, c))
      begin
        next_rdata[`CMPC_B_RISE] = ctrl[c].rise_en;
        next_rdata[`CMPC_B_FALL] = ctrl[c].fall_en;
      end
      if (is_ch(paddr, `CMPC_A_PSEL, c))
        next_rdata[`CMPC_SEL_W-1:0] = ctrl[c].psel;
      if (is_ch(paddr, `CMPC_A_NSEL, c))
        next_rdata[`CMPC_SEL_W-1:0] = ctrl[c].nsel;
    end
    if (paddr == `CMPC_A_MIRROR)
      next_rdata[NUM_CH-1:0] = cmp_result_bit;    // see R3
    if (paddr == `CMPC_A_IRQ_FLAG)
      next_rdata[NUM_CH-1:0] = cmp_irq_flag;
    if (paddr == `CMPC_A_IRQ_EN)
      next_rdata[NUM_CH-1:0] = cmp_irq_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : '0;
      pslverr <= psel && !penable && next_err;
    end
  end

endmodule

// *** cmpc_top_chk.sv ***
// Purpose: port checker for cmpc_top
// Assumes: registers at documented byte addresses
// Notes:   channel 0 is watched in detail
`include "cmpc_defs.svh"

module cmpc_top_chk
#(
  parameter int NUM_CH = 2
)
(
  input logic                               pclk,
  input logic                               presetn,
  input logic                               clk_en,
  input logic                               psel,
  input logic                               penable,
  input logic                               pwrite,
  input logic [11:0]                        paddr,
  input logic [31:0]                        pwdata,
  input logic [3:0]                         pstrb,
  input logic                               pready,
  input logic                               pslverr,
  input cmpc_pkg::cmpc_analog_t [NUM_CH-1:0] analog_ctrl,
  input logic [NUM_CH-1:0]                  gate_source,
  input logic [NUM_CH-1:0]                  pin_result,
  input logic [NUM_CH-1:0]                  cmp_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmpc_pkg::*;
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence wr_ctrl0;
    psel && penable && pready && pwrite && pstrb[0] && clk_en
      && paddr == `CMPC_A_CTRL_A;
  endsequence
  off_quiet_a: assert property (
    !analog_ctrl[0].power_on |-> analog_ctrl[0] == '0)
    else $error("routing active while powered down");
  plus_single_a: assert property ($onehot0({
    analog_ctrl[0].plus_pin_en, analog_ctrl[0].plus_dac,
    analog_ctrl[0].plus_fvr, analog_ctrl[0].plus_gnd}))
    else $error("two positive sources at once");
  minus_single_a: assert property ($onehot0({
    analog_ctrl[0].minus_pin_en, analog_ctrl[0].minus_fvr,
    analog_ctrl[0].minus_gnd}))
    else $error("two negative sources at once");
  flag_hold_a: assert property ($fell(cmp_irq_flag[0]) |->
    $past(psel && penable && pwrite && paddr == `CMPC_A_IRQ_FLAG))
    else $error("flag dropped without a clear");
  route_same_a: assert property (gate_source == pin_result)
    else $error("gate and pin results differ");
  setup_ready_a: assert property (psel && !penable && clk_en
    |=> pready) else $error("no answer after setup");
  err_ready_a: assert property (pslverr |-> pready && penable)
    else $error("error outside an access");
  hyst_on_a: assert property (
    wr_ctrl0 ##0 (pwdata[`CMPC_B_ENABLE] && pwdata[`CMPC_B_HYST]) |-> ##2
    analog_ctrl[0].power_on && analog_ctrl[0].hysteresis)
    else $error("hysteresis or power missing");
  power_off_a: assert property (
    wr_ctrl0 ##0 !pwdata[`CMPC_B_ENABLE] |-> ##2 analog_ctrl[0] == '0)
    else $error("powered after disable");
endmodule

bind cmpc_top cmpc_top_chk #(.NUM_CH(NUM_CH)) u_cmpc_top_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .analog_ctrl(analog_ctrl),
  .gate_source(gate_source), .pin_result(pin_result),
  .cmp_irq_flag(cmp_irq_flag));

// *** test_comparator_digital_control.sv ***
// Purpose: self-checking bench for cmpc_top
// Assumes: answer one cycle after setup
// Notes:   seed 56, random results and controls
`include "cmpc_defs.svh"

module test_comparator_digital_control;
  timeunit 1ns;
  timeprecision 1ps;
  import cmpc_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready;
  logic pslverr, timer_clk_post, tick_en, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [1:0] raw_result, gate_source, pin_result, cmp_irq_flag;
  logic [1:0] want, en, inv, ex;
  cmpc_analog_t [1:0] analog_ctrl;
  cmpc_analog_t g;
  int fails, checked;
  localparam logic [11:0] B0 = `CMPC_A_CTRL_B;
  localparam logic [11:0] FL = `CMPC_A_IRQ_FLAG;

  cmpc_top u_cmpc_top (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_result(raw_result), .timer_clk_post(timer_clk_post),
    .analog_ctrl(analog_ctrl), .gate_source(gate_source),
    .pin_result(pin_result), .cmp_irq_flag(cmp_irq_flag));
  cmpc_analog_model u_cmpc_analog_model (.pclk(pclk), .want(want),
    .tick_en(tick_en), .raw_result(raw_result),
    .timer_clk_post(timer_clk_post));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic more);
    if (psel !== 1'b1) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    penable <= 1'b0;
    if (!more)
    begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic cmpc_analog_t exp_sel(input logic [2:0] k);
    cmpc_analog_t x = '0;
    x.power_on = 1'b1;
    x.plus_pin_en = k < 3'h2;
    x.plus_pin = (k < 3'h2) ? k[1:0] : 2'h0;
    x.plus_dac = k == `CMPC_SEL_DAC;
    x.plus_fvr = k == `CMPC_SEL_FVR;
    x.plus_gnd = k == `CMPC_SEL_GND;
    x.minus_pin_en = k < 3'h4;
    x.minus_pin = (k < 3'h4) ? k[1:0] : 2'h0;
    x.minus_fvr = k == `CMPC_SEL_FVR;
    x.minus_gnd = k == `CMPC_SEL_GND;
    return x;
  endfunction
  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, tick_en, want} = '0;
    {paddr, pwdata} = '0;
    clk_en = 1'b1;
    pstrb = 4'hf;
    void'($urandom(56));
    pause(5);
    presetn <= 1'b1;
    apb(0, `CMPC_A_CTRL_A, 0, 0);
    chk(rdat, 0);
    apb(0, 12'h030, 0, 0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      want <= 2'($urandom);
      en = 2'($urandom);
      inv = 2'($urandom);
      for (int c = 0; c < 2; c++)
        apb(1, c ? `CMPC_CH_STRIDE : 12'h0, {24'h0, en[c], 2'b0,
          inv[c], 2'b0, en[c], 1'b0}, 0);
      pause(4);
      ex = (want & en) ^ inv;
      for (int c = 0; c < 2; c++)
      begin
        apb(0, c ? `CMPC_CH_STRIDE : 12'h0, 0, 0);
        chk(rdat, {24'h0, en[c], ex[c], 1'b0, inv[c], 2'b0, en[c],
          1'b0});
      end
      apb(0, `CMPC_A_MIRROR, 0, 0);
      chk(rdat, {30'h0, ex});
      chk({28'h0, pin_result, gate_source}, {28'h0, ex, ex});
    end
    $display("test result done");
    for (int k = 0; k < 8; k++)
    begin
      apb(1, `CMPC_CH_STRIDE, 32'h80, 0);
      apb(1, `CMPC_CH_STRIDE + `CMPC_A_PSEL, k, 0);
      apb(1, `CMPC_CH_STRIDE + `CMPC_A_NSEL, k, 0);
      pause(3);
      g = analog_ctrl[1];
      if (!g.plus_pin_en) g.plus_pin = 2'h0;
      if (!g.minus_pin_en) g.minus_pin = 2'h0;
      chk(32'(g), 32'(exp_sel(3'(k))));
    end
    $display("test select done");
    apb(1, `CMPC_A_IRQ_EN, 3, 0);
    apb(0, `CMPC_A_IRQ_EN, 0, 0);
    chk(rdat, 32'h3);
    want <= 2'h0;
    apb(1, B0, 2, 0);
    apb(1, `CMPC_A_CTRL_A, 0, 0);
    pause(4);
    apb(1, FL, 3, 0);
    apb(1, `CMPC_A_CTRL_A, 32'h10, 0);
    pause(4);
    chk(cmp_irq_flag[0], 1);
    pause(40);
    chk(cmp_irq_flag[0], 1);
    apb(1, FL, 1, 0);
    apb(1, `CMPC_A_CTRL_A, 0, 0);
    pause(4);
    chk(cmp_irq_flag[0], 0);
    apb(1, B0, 1, 0);
    apb(1, `CMPC_A_CTRL_A, 32'h10, 0);
    pause(4);
    chk(cmp_irq_flag[0], 0);
    apb(1, `CMPC_A_CTRL_A, 0, 0);
    pause(4);
    chk(cmp_irq_flag[0], 1);
    apb(1, B0, 3, 0);
    apb(1, `CMPC_A_CTRL_A, 32'h10, 1);
    apb(1, FL, 1, 0);
    pause(4);
    chk(cmp_irq_flag[0], 1);
    $display("test flag done");
    // Gate use with sync on is how software should run it
    apb(1, `CMPC_A_CTRL_A, 32'h81, 0);
    tick_en <= 1'b1;
    while (timer_clk_post !== 1'b1) @(posedge pclk);
    tick_en <= 1'b0;
    want <= 2'h1;
    pause(10);
    chk(gate_source[0], 0);
    tick_en <= 1'b1;
    while (timer_clk_post !== 1'b0) @(posedge pclk);
    pause(3);
    chk({pin_result[0], gate_source[0]}, 2'h3);
    $display("test sync done");
    // Clock enable low freezes the latched results
    clk_en <= 1'b0;
    want <= 2'h0;
    pause(6);
    chk({pin_result[0], gate_source[0]}, 2'h3);
    clk_en <= 1'b1;
    pause(2);
    $display("test clock enable done");
    report_and_stop();
  end
  initial
  begin
    pause(20000);
    fails++;
    report_and_stop();
  end
endmodule
